// >>> hw/rx_cfg_pkg.sv
`default_nettype none
package rx_cfg_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [5:0] idx_p2p_demod_config = 6'h0b;
  localparam logic [5:0] idx_correlator_config_a = 6'h0c;
  localparam logic [5:0] idx_correlator_config_b = 6'h0d;
  localparam logic [5:0] idx_status = 6'h0e;
  localparam logic [7:0] rst_p2p_demod_config = 8'h0c;
  localparam logic [7:0] rst_correlator_config_a = 8'h93;
  localparam logic [7:0] rst_correlator_config_b = 8'h00;
  localparam logic [7:0] mask_correlator_config_b = 8'h03;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;
  localparam int clk_mhz = 40;
  localparam int sleep_entry_ns = 18000;
  localparam int wake_short_ns = 18000;
  localparam int wake_long_ns = 42000;
  localparam int sleep_entry_cycles = sleep_entry_ns * clk_mhz / 1000;
  localparam int wake_short_cycles = wake_short_ns * clk_mhz / 1000;
  localparam int wake_long_cycles = wake_long_ns * clk_mhz / 1000;
  // Decoded settings, in tenths of a microsecond, in percent and in pilot pulses.
  localparam logic [6:0] onoff_rc_tenths[4] = '{7'h0e, 7'h0a, 7'h06, 7'h02};
  localparam logic [6:0] onoff_thr_low[4] = '{7'h37, 7'h2d, 7'h23, 7'h19};
  localparam logic [6:0] onoff_thr_high[4] = '{7'h50, 7'h4b, 7'h46, 7'h41};
  localparam logic [6:0] ampshift_rc_tenths[4] = '{7'h54, 7'h44, 7'h2c, 7'h18};
  localparam logic [6:0] ampshift_thr_clr = 7'h61;
  localparam logic [6:0] ampshift_thr_set = 7'h5f;
  localparam logic [6:0] coll_level_pct[4] = '{7'h10, 7'h1c, 7'h29, 7'h35};
  localparam logic [6:0] end_level_full = 7'h64;
  localparam logic [6:0] end_level_part = 7'h42;
  localparam logic [5:0] start_len_a106 = 6'h21;
  localparam logic [5:0] start_len_other = 6'h11;
  typedef enum logic [1:0] {std_a106, std_a_hbr, std_b, std_other} rx_std_t;
endpackage : rx_cfg_pkg
`default_nettype wire

// >>> hw/corr_sleep_if.sv
`default_nettype none
interface corr_sleep_if;
  logic sleep_exit_select;
  logic long_wake;
  logic rx_on;
  logic corr_pulse;
  logic asleep;
  modport ctl (output sleep_exit_select, output long_wake, output rx_on, output corr_pulse, input asleep);
  modport tmr (input sleep_exit_select, input long_wake, input rx_on, input corr_pulse, output asleep);
endinterface : corr_sleep_if
`default_nettype wire

// >>> hw/corr_sleep_timer.sv
`default_nettype none
module corr_sleep_timer #(
  parameter int sleep_cycles = rx_cfg_pkg::sleep_entry_cycles,
  parameter int wake_short = rx_cfg_pkg::wake_short_cycles,
  parameter int wake_long = rx_cfg_pkg::wake_long_cycles
) (
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  corr_sleep_if.tmr sl // Sleep controls and state.
);
  typedef enum logic {awake, sleeping} st_t;
  typedef struct packed {
    st_t st;
    logic [11:0] cnt;
  } state_t;
  state_t q, d;
  initial begin
    if (sleep_cycles < 1 || wake_long >= 4096 || wake_short < 1) $error("bad sleep timing");
  end
  always_comb begin
    d = q;
    unique case (q.st)
      awake: begin
        if (sl.corr_pulse) begin
          d.cnt = '0;
        end else if (q.cnt >= 12'(sleep_cycles - 1)) begin
          d.st = sleeping;
          d.cnt = '0;
        end else begin
          d.cnt = q.cnt + 12'h001;
        end
      end
      sleeping: begin
        if (sl.sleep_exit_select) begin
          if (sl.rx_on) begin
            d.st = awake;
            d.cnt = '0;
          end
        end else if (q.cnt >= 12'(sl.long_wake ? wake_long - 1 : wake_short - 1)) begin
          d.st = awake;
          d.cnt = '0;
        end else begin
          d.cnt = q.cnt + 12'h001;
        end
      end
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{st: awake, cnt: 12'h000};
    end else begin
      q <= d;
    end
  end
  assign sl.asleep = (q.st == sleeping);
endmodule : corr_sleep_timer
`default_nettype wire

// >>> hw/rx_demod_correlator_config.sv
`default_nettype none
module rx_demod_correlator_config (
  input wire logic hclk, // System clock, 40 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [7:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic [31:0] hrdata, // Read data.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Always OKAY.
  input wire rx_cfg_pkg::rx_std_t rx_std, // Reception standard.
  input wire logic wake_long_mode, // Stream vicinity or 212 type-F.
  input wire logic rx_on, // Receiver on, from another domain.
  input wire logic corr_pulse, // Correlator output pulse, pin.
  input wire logic start_seen, // Subcarrier start detected.
  input wire logic phase_edge, // Phase transition seen.
  input wire logic first_bytes_done, // First data bytes received.
  output logic onoff_fast_decay, // Fast decay enable.
  output logic [6:0] onoff_rc_tenths, // RC constant, 0.1 us.
  output logic [6:0] onoff_threshold_pct, // Threshold percent.
  output logic [6:0] ampshift_rc_tenths, // RC constant, 0.1 us.
  output logic [6:0] ampshift_threshold_pct, // Threshold percent.
  output logic agc_max_select, // AGC on max of channels.
  output logic squelch_step_select, // Squelch step choice.
  output logic coll_from_slicer, // Collision level equals slicer.
  output logic [6:0] coll_level_pct, // Collision level percent.
  output logic fast_slicer, // Fast data slicer.
  output logic phase_correct_on, // Phase correction active.
  output logic long_reference, // Reference 1.5x normal.
  output logic [6:0] end_level_pct, // End detection level.
  output logic end_detect_on, // End detector enable.
  output logic channel_summation, // Sum channels before digitizing.
  output logic [5:0] start_length, // Start length in pilot pulses.
  output logic start_check, // Start-time check pulse.
  output logic subcarrier_stream_select, // Stream mode.
  output logic corr_asleep // Correlator sleeping.
);
  typedef struct packed {
    logic [7:0] p2p;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic ph_wr;
    logic [5:0] ph_idx;
    logic ph_read;
    logic [31:0] rdata;
    logic watching;
    logic check;
    logic hold_done;
    logic [1:0] rx_on_s;
    logic [1:0] pulse_s;
  } state_t;
  state_t q, d;
  logic phase_keyed;
  logic take;
  corr_sleep_if sl ();
  corr_sleep_timer u_sleep (
    .hclk(hclk),
    .hresetn(hresetn),
    .sl(sl)
  );
  assign phase_keyed = (rx_std == rx_cfg_pkg::std_a_hbr) || (rx_std == rx_cfg_pkg::std_b);
  // Only whole-word transfers are served; other sizes are ignored so hsize is honoured, not dropped.
  assign take = hsel && hready && (htrans == rx_cfg_pkg::htrans_nonseq) && (hsize == rx_cfg_pkg::hsize_word);
  always_comb begin
    d = q;
    d.rx_on_s = {q.rx_on_s[0], rx_on};
    d.pulse_s = {q.pulse_s[0], corr_pulse};
    d.ph_wr = 1'b0;
    d.ph_read = 1'b0;
    if (q.ph_wr) begin
      unique case (q.ph_idx)
        rx_cfg_pkg::idx_p2p_demod_config: d.p2p = hwdata[7:0];
        rx_cfg_pkg::idx_correlator_config_a: d.cfg_a = hwdata[7:0];
        rx_cfg_pkg::idx_correlator_config_b: d.cfg_b = hwdata[7:0] & rx_cfg_pkg::mask_correlator_config_b;
        default: ;
      endcase
    end
    if (take) begin
      d.ph_wr = hwrite;
      d.ph_read = !hwrite;
      d.ph_idx = haddr[7:2];
      d.rdata = '0;
      if (!hwrite) begin
        unique case (haddr[7:2])
          rx_cfg_pkg::idx_p2p_demod_config: d.rdata = {24'h000000, q.p2p};
          rx_cfg_pkg::idx_correlator_config_a: d.rdata = {24'h000000, q.cfg_a};
          rx_cfg_pkg::idx_correlator_config_b: d.rdata = {24'h000000, q.cfg_b};
          rx_cfg_pkg::idx_status: d.rdata = {29'h0, q.hold_done, q.watching, sl.asleep};
          default: d.rdata = '0;
        endcase
      end
    end
    d.check = 1'b0;
    if (!phase_keyed) begin
      d.watching = 1'b0;
      d.hold_done = 1'b0;
    end else begin
      if (start_seen) begin
        d.watching = 1'b1;
      end else if (q.watching && phase_edge) begin
        d.watching = 1'b0;
        d.check = 1'b1;
      end
      if (first_bytes_done) begin
        d.hold_done = 1'b1;
      end else if (start_seen) begin
        d.hold_done = 1'b0;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.p2p <= rx_cfg_pkg::rst_p2p_demod_config;
      q.cfg_a <= rx_cfg_pkg::rst_correlator_config_a;
      q.cfg_b <= rx_cfg_pkg::rst_correlator_config_b;
    end else begin
      q <= d;
    end
  end
  // Zero-wait slave: writes land one cycle after the data phase, which is harmless for static settings.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign sl.sleep_exit_select = q.cfg_b[1];
  assign sl.long_wake = wake_long_mode;
  assign sl.rx_on = q.rx_on_s[1];
  assign sl.corr_pulse = q.pulse_s[1];
  assign corr_asleep = sl.asleep;
  assign onoff_fast_decay = q.p2p[7];
  assign onoff_rc_tenths = rx_cfg_pkg::onoff_rc_tenths[q.p2p[6:5]];
  assign onoff_threshold_pct = (q.p2p[6:5] == 2'h0) ? rx_cfg_pkg::onoff_thr_low[q.p2p[4:3]] :
      rx_cfg_pkg::onoff_thr_high[q.p2p[4:3]];
  assign ampshift_rc_tenths = rx_cfg_pkg::ampshift_rc_tenths[q.p2p[2:1]];
  assign ampshift_threshold_pct = q.p2p[0] ? rx_cfg_pkg::ampshift_thr_set : rx_cfg_pkg::ampshift_thr_clr;
  assign agc_max_select = q.cfg_a[7];
  assign squelch_step_select = q.cfg_a[5];
  assign coll_from_slicer = (rx_std == rx_cfg_pkg::std_a106) && q.cfg_a[6];
  assign coll_level_pct = rx_cfg_pkg::coll_level_pct[q.cfg_a[1:0]];
  assign fast_slicer = (rx_std == rx_cfg_pkg::std_a106) && q.cfg_a[3];
  assign phase_correct_on = phase_keyed && !(q.cfg_a[6] && q.hold_done);
  assign long_reference = phase_keyed && q.cfg_a[2];
  assign end_level_pct = q.cfg_a[1] ? rx_cfg_pkg::end_level_part : rx_cfg_pkg::end_level_full;
  assign end_detect_on = phase_keyed && q.cfg_a[0];
  assign channel_summation = q.cfg_a[4];
  assign start_length = (rx_std == rx_cfg_pkg::std_a106 || !q.cfg_a[3]) ? rx_cfg_pkg::start_len_a106 :
      rx_cfg_pkg::start_len_other;
  assign start_check = q.check;
  assign subcarrier_stream_select = q.cfg_b[0];
endmodule : rx_demod_correlator_config
`default_nettype wire

// >>> test/rx_cfg_properties.sv
`default_nettype none
module rx_cfg_properties (
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset.
  input wire logic hresp, // Response.
  input wire logic [6:0] onoff_rc_tenths, // Decode.
  input wire logic [6:0] onoff_threshold_pct, // Decode.
  input wire logic [6:0] ampshift_threshold_pct, // Decode.
  input wire logic [6:0] coll_level_pct, // Decode.
  input wire logic [6:0] end_level_pct, // Decode.
  input wire logic start_check, // Pulse.
  input wire logic phase_edge, // Input.
  input wire logic corr_pulse, // Input.
  input wire logic corr_asleep // State.
);
  timeunit 1ns;
  timeprecision 1ps;
  // The design sees pulses two flops late, so its quiet count never leads this one.
  int quiet_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) quiet_q <= 0;
    else if (corr_pulse) quiet_q <= 0;
    else if (quiet_q < 4000) quiet_q <= quiet_q + 1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  thr_low_a: assert property (onoff_rc_tenths == 7'h0e |-> onoff_threshold_pct inside {7'h37, 7'h2d, 7'h23, 7'h19})
    else $error("low threshold");
  thr_high_a: assert property (onoff_rc_tenths != 7'h0e |-> onoff_threshold_pct inside {7'h50, 7'h4b, 7'h46, 7'h41})
    else $error("high threshold");
  ampshift_thr_a: assert property (ampshift_threshold_pct inside {7'h61, 7'h5f})
    else $error("ampshift threshold");
  coll_level_a: assert property (coll_level_pct inside {7'h10, 7'h1c, 7'h29, 7'h35})
    else $error("collision level");
  end_level_a: assert property (end_level_pct inside {7'h64, 7'h42})
    else $error("end level");
  check_cause_a: assert property (start_check |-> $past(phase_edge))
    else $error("start check cause");
  check_pulse_a: assert property (start_check |=> !start_check)
    else $error("start check width");
  sleep_quiet_a: assert property ($rose(corr_asleep) |-> quiet_q >= 700)
    else $error("early sleep");
  sleep_hold_a: assert property ($rose(corr_asleep) |-> corr_asleep [*8])
    else $error("short sleep");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bad response");
  cover property (start_check);
  cover property ($fell(corr_asleep));
  cover property (coll_level_pct == 7'h35);
endmodule : rx_cfg_properties
bind rx_demod_correlator_config rx_cfg_properties props (.hclk, .hresetn, .hresp, .onoff_rc_tenths,
  .onoff_threshold_pct, .ampshift_threshold_pct, .coll_level_pct, .end_level_pct, .start_check,
  .phase_edge, .corr_pulse, .corr_asleep);
`default_nettype wire

// >>> test/rx_demod_correlator_config_bench.sv
`default_nettype none
module rx_demod_correlator_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {rx_cfg_pkg::rx_std_t s; logic [5:0] i; logic [7:0] d; logic [20:0] e;} row_t;
  localparam rx_cfg_pkg::rx_std_t a106 = rx_cfg_pkg::std_a106;
  localparam rx_cfg_pkg::rx_std_t bstd = rx_cfg_pkg::std_b;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, wake_long_mode = 1'b0, rx_on = 1'b0;
  logic corr_pulse = 1'b0, start_seen = 1'b0, phase_edge = 1'b0, first_bytes_done = 1'b0, hreadyout, hresp;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = rx_cfg_pkg::hsize_word;
  logic [31:0] hwdata = 32'h0, hrdata, v;
  rx_cfg_pkg::rx_std_t rx_std = a106;
  logic [6:0] onoff_rc_tenths, onoff_threshold_pct, ampshift_rc_tenths, ampshift_threshold_pct;
  logic [6:0] coll_level_pct, end_level_pct;
  logic [5:0] start_length;
  logic coll_from_slicer, fast_slicer, phase_correct_on, long_reference, end_detect_on, channel_summation;
  logic start_check, subcarrier_stream_select, corr_asleep;
  logic onoff_fast_decay, agc_max_select, squelch_step_select;
  int n_mismatch = 0, checks_done = 0, c;
  row_t rows[15] = '{'{a106, 6'h0b, 8'h00, {7'h0e, 7'h37, 7'h54}}, '{a106, 6'h0b, 8'h08, {7'h0e, 7'h2d, 7'h54}},
    '{a106, 6'h0b, 8'h14, {7'h0e, 7'h23, 7'h2c}}, '{a106, 6'h0b, 8'h18, {7'h0e, 7'h19, 7'h54}},
    '{a106, 6'h0b, 8'h60, {7'h02, 7'h50, 7'h54}}, '{a106, 6'h0b, 8'h2a, {7'h0a, 7'h4b, 7'h44}},
    '{a106, 6'h0b, 8'h50, {7'h06, 7'h46, 7'h54}}, '{a106, 6'h0b, 8'h7f, {7'h02, 7'h41, 7'h18}},
    '{a106, 6'h0c, 8'h00, {7'h10, 7'h00, 7'h00}}, '{a106, 6'h0c, 8'h51, {7'h1c, 7'h05, 7'h00}},
    '{a106, 6'h0c, 8'h0a, {7'h29, 7'h02, 7'h00}}, '{a106, 6'h0c, 8'h93, {7'h35, 7'h01, 7'h00}},
    '{bstd, 6'h0c, 8'h00, {7'h64, 7'h00, 7'h21}}, '{bstd, 6'h0c, 8'h1f, {7'h42, 7'h07, 7'h11}},
    '{rx_cfg_pkg::std_a_hbr, 6'h0c, 8'h06, {7'h42, 7'h02, 7'h21}}};
  rx_demod_correlator_config dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_std, .wake_long_mode, .rx_on, .corr_pulse, .start_seen,
    .phase_edge, .first_bytes_done, .onoff_fast_decay, .onoff_rc_tenths, .onoff_threshold_pct,
    .ampshift_rc_tenths, .ampshift_threshold_pct, .agc_max_select, .squelch_step_select, .coll_from_slicer,
    .coll_level_pct, .fast_slicer, .phase_correct_on, .long_reference, .end_level_pct, .end_detect_on,
    .channel_summation, .start_length, .start_check, .subcarrier_stream_select, .corr_asleep);
  always #12.5 hclk = ~hclk;
  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [31:0] r);
    int n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= rx_cfg_pkg::htrans_nonseq;
    hwrite <= w;
    haddr <= {i, 2'h0};
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
    if (n >= 50) begin n_mismatch++; final_report(); end
  endtask : bus
  // Waits for sleep, then counts its length; a length of 2000 means it never ended.
  task automatic nap(output int k);
    int n = 0;
    while (corr_asleep !== 1'b1 && n < 2000) begin @(posedge hclk); n++; end
    k = 0;
    while (corr_asleep === 1'b1 && k < 2000) begin @(posedge hclk); k++; end
    if (n >= 2000) begin n_mismatch++; final_report(); end
  endtask : nap
  function automatic logic [20:0] obs(input logic [5:0] i, input rx_cfg_pkg::rx_std_t s);
    if (i == 6'h0b) return {onoff_rc_tenths, onoff_threshold_pct, ampshift_rc_tenths};
    if (s == a106) return {coll_level_pct, 4'h0, coll_from_slicer, fast_slicer, channel_summation, 7'h00};
    return {end_level_pct, 4'h0, end_detect_on, long_reference, channel_summation, 1'h0, start_length};
  endfunction : obs
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[k]) begin
      rx_std <= rows[k].s;
      bus(1'b1, rows[k].i, rows[k].d, v);
      bus(1'b0, rows[k].i, 8'h00, v);
      chk(v, {24'h0, rows[k].d});
      chk(obs(rows[k].i, rows[k].s), rows[k].e);
    end
    bus(1'b1, 6'h0d, 8'hff, v);
    bus(1'b0, 6'h0d, 8'h00, v);
    chk({v[30:0], subcarrier_stream_select}, 32'h7);
    bus(1'b1, 6'h3f, 8'hff, v);
    bus(1'b0, 6'h3f, 8'h00, v);
    chk(v, 32'h0);
    bus(1'b1, 6'h0d, 8'h00, v);
    corr_pulse <= 1'b1;
    repeat (3) @(posedge hclk);
    corr_pulse <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      wake_long_mode <= m[0];
      nap(c);
      nap(c);
      chk((c + 2 - (m ? rx_cfg_pkg::wake_long_cycles : rx_cfg_pkg::wake_short_cycles)) inside {[0:4]}, 1'h1);
    end
    bus(1'b1, 6'h0d, 8'h02, v);
    nap(c);
    chk(c, 2000);
    rx_on <= 1'b1;
    nap(c);
    chk(c < 8, 1'h1);
    rx_on <= 1'b0;
    rx_std <= bstd;
    bus(1'b1, 6'h0c, 8'h50, v);
    @(posedge hclk) start_seen <= 1'b1;
    @(posedge hclk) start_seen <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      phase_edge <= 1'b1;
      @(posedge hclk) phase_edge <= 1'b0;
      #1 chk(start_check, p == 0);
      @(posedge hclk);
    end
    chk(phase_correct_on, 1'h1);
    @(posedge hclk) first_bytes_done <= 1'b1;
    @(posedge hclk) first_bytes_done <= 1'b0;
    @(posedge hclk) #1 chk(phase_correct_on, 1'h0);
    @(posedge hclk) hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 6'h0b, 8'h00, v);
    chk(v, {24'h0, rx_cfg_pkg::rst_p2p_demod_config});
    chk({obs(6'h0b, a106), ampshift_threshold_pct}, {7'h0e, 7'h2d, 7'h2c, 7'h61});
    bus(1'b0, 6'h0c, 8'h00, v);
    chk(v, {24'h0, rx_cfg_pkg::rst_correlator_config_a});
    chk({onoff_fast_decay, agc_max_select, squelch_step_select}, 32'h2);
    final_report();
  end
endmodule : rx_demod_correlator_config_bench
`default_nettype wire
